/* File: mem_model.sv */
// Purpose: Cache and memory model behind the word load unit
// Assumes: Byte value derived from its address
// Notes:   Latency and faults set by the bench
`timescale 1ns/1ps
module mem_model
	import word_load_pkg::*;
(
	input  logic       ref_clk,
	input  logic       arst_n,
	input  mem_req_t   memOut,
	input  logic       slow,
	input  logic [2:0] flt,
	output mem_rsp_t   memIn
);
	// ****
	// Responder
	// ****
	logic [3:0] waitQ;
	function automatic logic [7:0] mb(logic [31:0] a);
		return a[7:0] ^ 8'h5a;
	endfunction
	wire [31:0] wa = {memOut.addr[31:2], 2'b00};
	wire        go = memOut.valid && !memIn.ack && waitQ >= (slow ? 4'h3 : 4'h0);
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			memIn <= '0;
			waitQ <= 4'h0;
		end else begin
			waitQ <= (go || !memOut.valid) ? 4'h0 : waitQ + 4'h1;
			memIn.ack <= go;
			memIn.busErr <= go & flt[2];
			memIn.protFault <= go & flt[1];
			memIn.cachable <= go & flt[0];
			memIn.lineFill <= go & flt[0];
			memIn.rdata <= go ? {mb(wa), mb(wa + 32'h1), mb(wa + 32'h2), mb(wa + 32'h3)} : ~memIn.rdata;
		end
	end
endmodule

/* File: word_load_pkg.sv */
// Purpose: Shared constants and types for the word load unit
// Assumes: APB register map with 32-bit data, one word per register
// Notes:   Memory port is same-clock logic toward the data cache
package word_load_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int unsigned ADDR_W      = 8;
	localparam logic [7:0]  CMD_OFS     = 8'h00;
	localparam logic [7:0]  DISP_OFS    = 8'h04;
	localparam logic [7:0]  FXER_OFS    = 8'h08;
	localparam logic [7:0]  STATE_OFS   = 8'h0c;
	localparam logic [7:0]  ISTAT_OFS   = 8'h10;
	localparam logic [7:0]  IMASK_OFS   = 8'h14;
	localparam logic [7:0]  GSEL_OFS    = 8'h18;
	localparam logic [7:0]  GDATA_OFS   = 8'h1c;

	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam int unsigned TBC_LSB     = 0;
	localparam int unsigned TBC_W       = 7;
	localparam int unsigned ST_BUSY     = 0;
	localparam int unsigned ST_RESV     = 1;
	localparam int unsigned ST_CR0EQ    = 2;
	localparam int unsigned IRQ_DONE    = 0;
	localparam int unsigned IRQ_ALIGN   = 1;
	localparam int unsigned IRQ_DSTOR   = 2;
	localparam int unsigned IRQ_MCHK    = 3;
	localparam int unsigned IRQ_W       = 4;
	localparam logic [31:0] DISP_RST    = 32'h0000_0000;
	localparam logic [6:0]  TBC_RST     = 7'h00;
	localparam logic [3:0]  IMASK_RST   = 4'h0;
	localparam logic [31:0] GPR_RST     = 32'h0000_0000;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		LD_DISP, LD_DISP_UPD, LD_IDX, LD_IDX_UPD,
		LD_RESERVE, LD_BYTEREV, LD_STRING, ST_COND
	} op_t;

	typedef struct packed {
		logic       rec;
		logic [1:0] pad2;
		logic [4:0] idx;
		logic [2:0] pad1;
		logic [4:0] base;
		logic [2:0] pad0;
		logic [4:0] tgt;
		logic [4:0] pad;
		op_t        op;
	} cmd_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        probe;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mem_req_t;

	typedef struct packed {
		logic        ack;
		logic        busErr;
		logic        protFault;
		logic        cachable;
		logic        lineFill;
		logic [31:0] rdata;
	} mem_rsp_t;

endpackage

/* File: word_load_unit.sv */
// Purpose: Word load execution unit with string load and reservation
// Assumes: Memory answers with a one-cycle ack pulse, same clock
// Notes:   Registers reached over APB, zero wait states
`timescale 1ns/1ps

module word_load_unit
	import word_load_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output mem_req_t               memOut,
	input  mem_rsp_t               memIn,
	output logic                   irq
);

	// ****************************************
	// State
	// ****************************************
	typedef enum logic {IDLE, ACCESS} state_t;

	state_t            state_q, state_d;
	logic [31:0]       gpr_q [32];
	cmd_t              cmd_q, cmd_d;
	logic [31:0]       disp_q;
	logic [31:0]       ea_q, ea_d;
	logic [6:0]        tbc_q;
	logic [6:0]        cnt_q, cnt_d;
	logic [4:0]        reg_q, reg_d;
	logic [4:0]        final_q, final_d;
	logic [4:0]        gsel_q;
	logic [1:0]        lane_q, lane_d;
	logic              probe_q, probe_d;
	logic              resv_q, resv_d;
	logic              cr0Eq_q, cr0Eq_d;
	logic [31:0]       stateWord;
	logic [IRQ_W-1:0]  istat_q, imask_q, irqSet;

	// ****************************************
	// APB decode
	// ****************************************
	wire logic        apbAccess = psel & penable;
	wire logic        apbWr     = apbAccess & pwrite;
	wire logic        apbRd     = apbAccess & ~pwrite;
	wire logic        hitCmd    = paddr == CMD_OFS;
	wire logic        hitDisp   = paddr == DISP_OFS;
	wire logic        hitFxer   = paddr == FXER_OFS;
	wire logic        hitState  = paddr == STATE_OFS;
	wire logic        hitIstat  = paddr == ISTAT_OFS;
	wire logic        hitImask  = paddr == IMASK_OFS;
	wire logic        hitGsel   = paddr == GSEL_OFS;
	wire logic        hitGdata  = paddr == GDATA_OFS;
	wire logic        mapped    = hitCmd | hitDisp | hitFxer | hitState | hitIstat | hitImask | hitGsel
		| hitGdata;
	wire cmd_t        newCmd    = cmd_t'(pwdata);
	wire logic        seqIdle   = state_q == IDLE;
	wire logic        issue     = apbWr & hitCmd & seqIdle;
	wire logic        istatClr  = apbRd & hitIstat;

	assign pready  = 1'b1;
	assign pslverr = apbAccess & ~mapped;
	// Status word from the named field positions
	always_comb begin
		stateWord           = 32'h0000_0000;
		stateWord[ST_BUSY]  = ~seqIdle;
		stateWord[ST_RESV]  = resv_q;
		stateWord[ST_CR0EQ] = cr0Eq_q;
	end

	wire logic [31:0] fxerWord  = 32'(tbc_q) << TBC_LSB;
	wire logic [31:0] istatWord = {28'h000_0000, istat_q};
	wire logic [31:0] imaskWord = {28'h000_0000, imask_q};
	wire logic [31:0] gselWord  = {27'h000_0000, gsel_q};
	wire logic [31:0] gdataWord = gpr_q[gsel_q];
	wire logic [31:0] readWord  = hitCmd ? cmd_q :
		hitDisp  ? disp_q :
		hitFxer  ? fxerWord :
		hitState ? stateWord :
		hitIstat ? istatWord :
		hitImask ? imaskWord :
		hitGsel  ? gselWord :
		hitGdata ? gdataWord : 32'h0000_0000;

	assign prdata  = apbRd ? readWord : 32'h0000_0000;

	// ****************************************
	// Effective address at issue
	// ****************************************
	wire logic [31:0] baseVal   = (newCmd.base == 5'h00) ? 32'h0000_0000 : gpr_q[newCmd.base];
	wire logic [31:0] dispExt   = {{16{disp_q[15]}}, disp_q[15:0]};
	wire logic        dispForm  = (newCmd.op == LD_DISP) | (newCmd.op == LD_DISP_UPD);
	wire logic [31:0] newEa     = baseVal + (dispForm ? dispExt : gpr_q[newCmd.idx]);
	wire logic        misalign  = (newCmd.op == LD_RESERVE) & (newEa[1:0] != 2'b00);
	wire logic        zeroStr   = (newCmd.op == LD_STRING) & (tbc_q == 7'h00);
	wire logic        failCond  = (newCmd.op == ST_COND) & ~resv_q;
	wire logic [4:0]  newFinal  = newCmd.tgt + 5'(({1'b0, tbc_q} + 8'h03) >> 2) - 5'h01;

	// ****************************************
	// Data shaping
	// ****************************************
	wire logic [31:0] rd        = memIn.rdata;
	wire logic [31:0] laneShift = rd << {ea_q[1:0], 3'b000};
	wire logic [7:0]  strByte   = laneShift[31:24];
	wire logic [31:0] revWord   = {rd[7:0], rd[15:8], rd[23:16], rd[31:24]};
	wire logic [31:0] byteMask  = 32'hff00_0000 >> {lane_q, 3'b000};
	wire logic [31:0] byteIns   = {strByte, 24'h00_0000} >> {lane_q, 3'b000};
	wire logic [31:0] strWord   = (lane_q == 2'b00) ? byteIns : ((gpr_q[reg_q] & ~byteMask) | byteIns);
	wire logic        strDrop   = ((reg_q == cmd_q.base) | (reg_q == cmd_q.idx)) & (reg_q != final_q);

	// ****************************************
	// Response classification
	// ****************************************
	wire logic        ackNow    = (state_q == ACCESS) & memIn.ack;
	wire logic        probeMchk = memIn.cachable & memIn.lineFill & memIn.busErr & ~memIn.protFault;
	wire logic        goodAck   = ackNow & ~probe_q & ~memIn.protFault & ~memIn.busErr;
	wire logic        isString  = cmd_q.op == LD_STRING;
	wire logic        strMore   = isString & (cnt_q != 7'h01);
	wire logic        isUpd     = (cmd_q.op == LD_DISP_UPD) | (cmd_q.op == LD_IDX_UPD);

	wire logic        wrEn      = goodAck & (cmd_q.op != ST_COND) & ~(isString & strDrop);
	wire logic [4:0]  wrIdx     = isString ? reg_q : cmd_q.tgt;
	wire logic [31:0] wrData    = isString ? strWord : (cmd_q.op == LD_BYTEREV) ? revWord : rd;
	wire logic        updEn     = goodAck & isUpd;

	assign memOut.valid = state_q == ACCESS;
	assign memOut.write = cmd_q.op == ST_COND;
	assign memOut.probe = probe_q;
	assign memOut.addr  = ea_q;
	assign memOut.wdata = gpr_q[cmd_q.tgt];

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		state_d = state_q;
		cmd_d   = cmd_q;
		ea_d    = ea_q;
		cnt_d   = cnt_q;
		reg_d   = reg_q;
		lane_d  = lane_q;
		final_d = final_q;
		probe_d = probe_q;
		resv_d  = resv_q;
		cr0Eq_d = cr0Eq_q;
		irqSet  = '0;
		if (issue) begin
			cmd_d   = newCmd;
			ea_d    = newEa;
			cnt_d   = tbc_q;
			reg_d   = newCmd.tgt;
			lane_d  = 2'b00;
			final_d = newFinal;
			probe_d = zeroStr;
			if (misalign) begin
				irqSet[IRQ_ALIGN] = 1'b1;
			end else if (failCond) begin
				resv_d  = 1'b0;
				cr0Eq_d = 1'b0;
				irqSet[IRQ_DONE] = 1'b1;
			end else begin
				state_d = ACCESS;
			end
		end else if (ackNow) begin
			state_d = IDLE;
			if (probe_q) begin
				irqSet[IRQ_MCHK] = probeMchk;
				irqSet[IRQ_DONE] = 1'b1;
			end else if (memIn.protFault) begin
				irqSet[IRQ_DSTOR] = 1'b1;
			end else if (memIn.busErr) begin
				irqSet[IRQ_MCHK] = 1'b1;
			end else begin
				if (cmd_q.op == LD_RESERVE) begin
					resv_d = 1'b1;
				end
				if (cmd_q.op == ST_COND) begin
					resv_d  = 1'b0;
					cr0Eq_d = 1'b1;
				end
				if (strMore) begin
					state_d = ACCESS;
					ea_d    = ea_q + 32'h0000_0001;
					cnt_d   = cnt_q - 7'h01;
					lane_d  = lane_q + 2'b01;
					reg_d   = (lane_q == 2'b11) ? reg_q + 5'h01 : reg_q;
				end else begin
					irqSet[IRQ_DONE] = 1'b1;
				end
			end
		end
	end

	// ****************************************
	// Flip-flops
	// ****************************************
	// Sequencer state, command and address
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= IDLE;
			cmd_q   <= cmd_t'(32'h0000_0000);
			ea_q    <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			cmd_q   <= cmd_d;
			ea_q    <= ea_d;
		end
	end

	// String walk position
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q   <= TBC_RST;
			reg_q   <= 5'h00;
			lane_q  <= 2'b00;
			final_q <= 5'h00;
			probe_q <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			reg_q   <= reg_d;
			lane_q  <= lane_d;
			final_q <= final_d;
			probe_q <= probe_d;
		end
	end

	// Reservation and condition field equal bit
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			resv_q  <= 1'b0;
			cr0Eq_q <= 1'b0;
		end else begin
			resv_q  <= resv_d;
			cr0Eq_q <= cr0Eq_d;
		end
	end

	// ****************************************
	// Software registers
	// ****************************************
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			disp_q  <= DISP_RST;
			tbc_q   <= TBC_RST;
			imask_q <= IMASK_RST;
			gsel_q  <= 5'h00;
		end else begin
			if (apbWr & hitDisp) disp_q <= pwdata;
			if (apbWr & hitFxer) tbc_q <= pwdata[TBC_LSB +: TBC_W];
			if (apbWr & hitImask) imask_q <= pwdata[IRQ_W-1:0];
			if (apbWr & hitGsel) gsel_q <= pwdata[4:0];
		end
	end

	// ****************************************
	// Interrupt status: read clears, a new event wins
	// ****************************************
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			istat_q <= '0;
		end else begin
			istat_q <= (istatClr ? '0 : istat_q) | irqSet;
		end
	end

	assign irq = |(istat_q & imask_q);

	// ****************************************
	// General register file
	// ****************************************
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < 32; i++) gpr_q[i] <= GPR_RST;
		end else begin
			if (apbWr & hitGdata & seqIdle) gpr_q[gsel_q] <= pwdata;
			if (wrEn) gpr_q[wrIdx] <= wrData;
			if (updEn) gpr_q[cmd_q.base] <= ea_q;
		end
	end

endmodule

/* File: word_load_unit_bench.sv */
// Purpose: Self-checking bench for the word load unit
// Assumes: APB master and memory model
// Notes:   One task per scenario
`timescale 1ns/1ps
module word_load_unit_bench
	import word_load_pkg::*;
;
	// ****
	// Setup
	// ****
	logic              ref_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0]       pwdata = '0, prdata, rd;
	logic              pready, pslverr, irq, err;
	logic [2:0]        flt = 3'h0;
	mem_req_t          memOut;
	mem_rsp_t          memIn;
	int                error_cnt = 0, checks_done = 0, cyc = 0;
	word_load_unit u_word_load_unit(.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.memOut(memOut), .memIn(memIn), .irq(irq));
	mem_model u_mem_model(.ref_clk(ref_clk), .arst_n(arst_n), .memOut(memOut), .slow(slow), .flt(flt), .memIn(memIn));
	initial forever #5 ref_clk = ~ref_clk;
	function automatic logic [31:0] ew(logic [31:0] a);
		return {a[7:0] ^ 8'h5a, (a[7:0] + 8'h1) ^ 8'h5a, (a[7:0] + 8'h2) ^ 8'h5a, (a[7:0] + 8'h3) ^ 8'h5a};
	endfunction
	function automatic logic [31:0] mk(op_t o, logic [4:0] t, logic [4:0] b, logic [4:0] x);
		return {3'h0, x, 3'h0, b, 3'h0, t, 5'h0, o};
	endfunction
	task automatic final_report();
		if (error_cnt == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic gset(input logic [4:0] n, input logic [31:0] v);
		apb(1'b1, GSEL_OFS, {27'h0, n});
		apb(1'b1, GDATA_OFS, v);
	endtask
	task automatic gpr(input logic [4:0] n, input logic [31:0] e);
		apb(1'b1, GSEL_OFS, {27'h0, n});
		apb(1'b0, GDATA_OFS, 32'h0);
		chk(rd, e);
	endtask
	task automatic run(input logic [31:0] c);
		apb(1'b1, CMD_OFS, c);
		repeat (40) begin
			apb(1'b0, STATE_OFS, 32'h0);
			if (rd[ST_BUSY] === 1'b0) break;
		end
		if (rd[ST_BUSY] !== 1'b0) begin
			error_cnt++;
			$display("ERROR %0t unit still busy", $time);
		end
	endtask
	task automatic ist(input logic [31:0] e);
		apb(1'b0, ISTAT_OFS, 32'h0);
		chk(rd & 32'hf, e);
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_disp();
		gset(5'd3, 32'h100);
		apb(1'b1, DISP_OFS, 32'h0000_fffc);
		apb(1'b1, IMASK_OFS, 32'h1);
		run(mk(LD_DISP, 5'd5, 5'd3, 5'd0));
		gpr(5'd5, ew(32'hfc));
		chk({31'h0, irq}, 32'h1);
		ist(32'h1);
		ist(32'h0);
		chk({31'h0, irq}, 32'h0);
		run(mk(LD_DISP, 5'd6, 5'd0, 5'd0));
		gpr(5'd6, ew(32'hffff_fffc));
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, err}, 32'h1);
	endtask
	task automatic t_idx();
		logic [31:0] w;
		slow <= 1'b1;
		gset(5'd4, 32'h20);
		run(mk(LD_IDX_UPD, 5'd6, 5'd3, 5'd4));
		gpr(5'd6, ew(32'h120));
		gpr(5'd3, 32'h120);
		run(mk(LD_BYTEREV, 5'd7, 5'd0, 5'd4));
		w = ew(32'h20);
		gpr(5'd7, {w[7:0], w[15:8], w[23:16], w[31:24]});
		run(mk(LD_IDX, 5'd9, 5'd0, 5'd4));
		gpr(5'd9, ew(32'h20));
		slow <= 1'b0;
	endtask
	task automatic t_resv();
		run(mk(LD_RESERVE, 5'd8, 5'd0, 5'd4));
		chk(rd & 32'h2, 32'h2);
		gpr(5'd8, ew(32'h20));
		run(mk(ST_COND, 5'd8, 5'd0, 5'd4));
		chk(rd & 32'h6, 32'h4);
		run(mk(LD_IDX, 5'd13, 5'd0, 5'd4) | 32'h8000_0000);
		chk(rd & 32'h4, 32'h4);
		gpr(5'd13, ew(32'h20));
		run(mk(ST_COND, 5'd8, 5'd0, 5'd4));
		chk(rd & 32'h6, 32'h0);
		gset(5'd10, 32'h22);
		ist(32'h1);
		run(mk(LD_RESERVE, 5'd11, 5'd0, 5'd10));
		ist(32'h2);
	endtask
	task automatic t_str();
		gset(5'd12, 32'h0);
		gset(5'd0, 32'hffff_ffff);
		apb(1'b1, FXER_OFS, 32'h6);
		run(mk(LD_STRING, 5'd31, 5'd12, 5'd4));
		gpr(5'd31, ew(32'h20));
		gpr(5'd0, ew(32'h24) & 32'hffff_0000);
		gpr(5'd12, 32'h0);
		gpr(5'd4, 32'h20);
		apb(1'b1, FXER_OFS, 32'h0);
		ist(32'h1);
		flt <= 3'h2;
		run(mk(LD_STRING, 5'd9, 5'd0, 5'd10));
		gpr(5'd9, ew(32'h20));
		ist(32'h1);
		flt <= 3'h5;
		run(mk(LD_STRING, 5'd9, 5'd0, 5'd10));
		ist(32'h9);
		flt <= 3'h0;
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		arst_n <= 1'b1;
		t_disp();
		t_idx();
		t_resv();
		t_str();
		final_report();
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			final_report();
		end
	end
endmodule
bind word_load_unit word_load_unit_props u_word_load_unit_props(.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .memOut(memOut), .memIn(memIn), .irq(irq));

/* File: word_load_unit_props.sv */
// Purpose: Port assertions for the word load unit
// Assumes: Zero wait APB, one-cycle memory ack
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
module word_load_unit_props
	import word_load_pkg::*;
(
	input logic              ref_clk,
	input logic              arst_n,
	input logic              psel,
	input logic              penable,
	input logic              pwrite,
	input logic [ADDR_W-1:0] paddr,
	input logic [31:0]       pwdata,
	input logic [31:0]       prdata,
	input logic              pready,
	input logic              pslverr,
	input mem_req_t          memOut,
	input mem_rsp_t          memIn,
	input logic              irq
);
	// ****
	// Checks
	// ****
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	wire acc   = psel && penable;
	wire cmdWr = acc && pwrite && paddr == CMD_OFS && !pwdata[2];
	sequence waitAck; memOut.valid && !memIn.ack; endsequence
	sequence holdReq; memOut.valid && $stable(memOut.addr); endsequence
	a_ready_high: assert property (pready) else $error("pready low");
	a_slverr_acc: assert property (pslverr |-> acc) else $error("pslverr outside access");
	a_slverr_map: assert property (acc && paddr > GDATA_OFS |-> pslverr) else $error("no pslverr");
	a_prdata_idle: assert property (!(acc && !pwrite) |-> prdata == 32'h0) else $error("prdata not zero");
	a_req_hold: assert property (waitAck |=> holdReq) else $error("request dropped");
	a_probe_read: assert property (memOut.valid && memOut.probe |-> !memOut.write) else $error("probe writes");
	a_cmd_start: assert property (cmdWr && !memOut.valid |=> memOut.valid) else $error("no access");
	a_irq_clear: assert property (acc && !pwrite && paddr == ISTAT_OFS && !memOut.valid |=> !irq)
		else $error("irq stays");
endmodule
